// file: pcl_pkg.sv
// Purpose: shared constants and types for the programmable I/O cell
// Assumes: one 40 MHz clock, asynchronous active-high reset
// Notes: register offsets are byte addresses on the plain register port
package pcl_pkg;

  // clock rate of the block
  localparam int unsigned CLK_HZ = 40000000;

  // register port widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // control register field positions
  localparam int unsigned CTRL_IN_REG_BIT = 0;
  localparam int unsigned CTRL_OUT_REG_BIT = 1;
  localparam int unsigned CTRL_OE_REG_BIT = 2;
  localparam int unsigned CTRL_LATCH_EN_BIT = 3;
  localparam int unsigned CTRL_PULL_EN_BIT = 4;
  localparam int unsigned CTRL_PULL_SEL_LSB = 5;
  localparam int unsigned CTRL_USED_BIT = 7;
  localparam int unsigned CTRL_CFG_DONE_BIT = 8;
  localparam int unsigned CTRL_W = 9;

  // status register field positions
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_FROZEN_BIT = 2;
  localparam int unsigned STAT_PAD_BIT = 3;
  localparam int unsigned STAT_DIN0_BIT = 4;
  localparam int unsigned STAT_DIN1_BIT = 5;
  localparam int unsigned STAT_POR_BIT = 6;

  // pull-up strength codes, weakest is the default
  localparam logic [1:0] PULL_100K = 2'h0;
  localparam logic [1:0] PULL_10K = 2'h1;
  localparam logic [1:0] PULL_6K8 = 2'h2;
  localparam logic [1:0] PULL_3K3 = 2'h3;

  // control register after reset: pull-up on, weakest, nothing configured
  localparam logic [8:0] CTRL_RST = 9'h010;

  // synchroniser width: pad, input clock, output clock, power-on reset
  localparam int unsigned SYNC_W = 4;
  localparam logic [3:0] SYNC_RST = 4'h0;

  // cell operating mode
  typedef enum logic [1:0] {
    MODE_PRECFG = 2'b00,
    MODE_USER = 2'b01,
    MODE_UNUSED = 2'b10
  } pcl_mode_t;

  // pin-side inputs that cross into the clock domain
  typedef struct packed {
    logic por_active;
    logic out_clk;
    logic in_clk;
    logic pad;
  } pcl_async_t;

  // signals driven toward the pad buffer
  typedef struct packed {
    logic data;
    logic oe;
    logic pull_en;
    logic [1:0] pull_sel;
  } pcl_pad_t;

  // synchroniser state
  typedef struct packed {
    logic [3:0] stage1;
    logic [3:0] stage2;
  } pcl_sync_t;

  // whole state of the cell
  typedef struct packed {
    logic [8:0] ctrl;
    pcl_mode_t mode;
    logic in_q0;
    logic in_q1;
    logic in_hold;
    logic out_q0;
    logic out_q1;
    logic oe_q;
    logic in_clk_prev;
    logic out_clk_prev;
    pcl_pad_t pad;
    logic d_in_0;
    logic d_in_1;
    logic [31:0] rdata;
  } pcl_cell_t;

endpackage

// file: pcl_sync.sv
// Purpose: two-flop synchroniser for the pin-side inputs of the cell
// Assumes: inputs are asynchronous to clk
// Notes: only the second stage is visible outside
`timescale 1ns/100ps
module pcl_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);

  pcl_pkg::pcl_sync_t state_reg;
  pcl_pkg::pcl_sync_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // next state: first stage feeds only the second
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  // state flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{stage1: pcl_pkg::SYNC_RST, stage2: pcl_pkg::SYNC_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

endmodule

// file: pcl_cell.sv
// Purpose: programmable I/O cell between the core fabric and one pad
// Assumes: clk at 40 MHz; input_clk, output_clk, pad_in, por_active are
//   asynchronous pins and are synchronised before use
// Notes: register edges are the sampled edges of input_clk and output_clk
//
// Summary of operation
// - cell has input, output and output-enable register paths.
// - input path registers pad samples when selected, else passes through.
// - output path registered or direct, chosen by configuration.
// - enabled latch freezes the non-registered input while freeze is high.
// - one bank-wide freeze input holds every latch-enabled cell together.
// - asserting input-hold latches the non-registered input of a latch-enabled cell and presents it until release.
// - before configuration the pad is high impedance with weak pull-up.
// - user settings apply only after reset release and finished download.
// - core paths run only after power-on reset indication drops.
// - unused cells block input and turn the pull-up off.
// - each pad selects weak pull-up or no bus maintenance.
// - four pull-up strengths, weakest applied by default.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
module pcl_cell (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // core side
  input wire logic input_clk,
  input wire logic output_clk,
  input wire logic clock_enable,
  input wire logic output_enable,
  input wire logic d_out_0,
  input wire logic d_out_1,
  input wire logic latch_input_value,
  output logic d_in_0,
  output logic d_in_1,
  // pad side
  input wire logic pad_in,
  input wire logic por_active,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup_en,
  output logic [1:0] pad_pullup_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // rising edge of a sampled clock
  function automatic logic edge_rise(input logic cur, input logic prev);
    edge_rise = cur & ~prev;
  endfunction

  // falling edge of a sampled clock
  function automatic logic edge_fall(input logic cur, input logic prev);
    edge_fall = ~cur & prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pin inputs

  pcl_pkg::pcl_async_t async_pins;
  pcl_pkg::pcl_async_t sync_pins;
  logic [3:0] sync_vec;

  // pack the asynchronous pins for the synchroniser
  assign async_pins.por_active = por_active;
  assign async_pins.out_clk = output_clk;
  assign async_pins.in_clk = input_clk;
  assign async_pins.pad = pad_in;

  pcl_sync u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(async_pins),
    .sync_out(sync_vec)
  );

  assign sync_pins = sync_vec;

  ////////////////////////////////////////////////////////////////////////////
  // state

  pcl_pkg::pcl_cell_t state_reg;
  pcl_pkg::pcl_cell_t state_next;

  // decoded control fields
  logic cfg_in_reg;
  logic cfg_out_reg;
  logic cfg_oe_reg;
  logic cfg_latch_en;
  logic cfg_pull_en;
  logic [1:0] cfg_pull_sel;
  logic cfg_used;
  logic cfg_done;

  assign cfg_in_reg = state_reg.ctrl[pcl_pkg::CTRL_IN_REG_BIT];
  assign cfg_out_reg = state_reg.ctrl[pcl_pkg::CTRL_OUT_REG_BIT];
  assign cfg_oe_reg = state_reg.ctrl[pcl_pkg::CTRL_OE_REG_BIT];
  assign cfg_latch_en = state_reg.ctrl[pcl_pkg::CTRL_LATCH_EN_BIT];
  assign cfg_pull_en = state_reg.ctrl[pcl_pkg::CTRL_PULL_EN_BIT];
  assign cfg_pull_sel = state_reg.ctrl[pcl_pkg::CTRL_PULL_SEL_LSB +: 2];
  assign cfg_used = state_reg.ctrl[pcl_pkg::CTRL_USED_BIT];
  assign cfg_done = state_reg.ctrl[pcl_pkg::CTRL_CFG_DONE_BIT];

  // sampled clock edges and derived conditions
  logic in_rise;
  logic in_fall;
  logic out_rise;
  logic out_fall;
  logic core_run;
  logic frozen;

  assign in_rise = edge_rise(sync_pins.in_clk, state_reg.in_clk_prev);
  assign in_fall = edge_fall(sync_pins.in_clk, state_reg.in_clk_prev);
  assign out_rise = edge_rise(sync_pins.out_clk, state_reg.out_clk_prev);
  assign out_fall = edge_fall(sync_pins.out_clk, state_reg.out_clk_prev);

  assign core_run = (state_reg.mode == pcl_pkg::MODE_USER) & ~sync_pins.por_active;

  assign frozen = cfg_latch_en & latch_input_value;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.in_clk_prev = sync_pins.in_clk;
    state_next.out_clk_prev = sync_pins.out_clk;

    // control register write; status is read-only
    if (reg_wr && (reg_addr == pcl_pkg::CTRL_OFS)) begin
      state_next.ctrl = reg_wdata[pcl_pkg::CTRL_W-1:0];
    end

    case (state_reg.mode)
      pcl_pkg::MODE_PRECFG: begin
        if (!sync_pins.por_active && cfg_done) begin
          state_next.mode = cfg_used ? pcl_pkg::MODE_USER : pcl_pkg::MODE_UNUSED;
        end
      end
      pcl_pkg::MODE_USER, pcl_pkg::MODE_UNUSED: begin
        if (sync_pins.por_active || !cfg_done) begin
          state_next.mode = pcl_pkg::MODE_PRECFG;
        end else begin
          state_next.mode = cfg_used ? pcl_pkg::MODE_USER : pcl_pkg::MODE_UNUSED;
        end
      end
      default: begin
        state_next.mode = pcl_pkg::MODE_PRECFG;
      end
    endcase

    if (core_run && clock_enable) begin
      if (in_rise) begin
        state_next.in_q0 = sync_pins.pad;
      end
      if (in_fall) begin
        state_next.in_q1 = sync_pins.pad;
      end
      if (out_rise) begin
        state_next.out_q0 = d_out_0;
        state_next.oe_q = output_enable;
      end
      if (out_fall) begin
        state_next.out_q1 = d_out_1;
      end
    end

    if (!frozen) begin
      state_next.in_hold = sync_pins.pad;
    end

    // data toward the core, blocked unless the cell is in use
    if (core_run) begin
      if (cfg_in_reg) begin
        state_next.d_in_0 = state_next.in_q0;
        state_next.d_in_1 = state_next.in_q1;
      end else begin
        state_next.d_in_0 = state_next.in_hold;
        state_next.d_in_1 = state_next.in_hold;
      end
    end else begin
      state_next.d_in_0 = 1'b0;
      state_next.d_in_1 = 1'b0;
    end

    // pad buffer controls by mode
    case (state_next.mode)
      pcl_pkg::MODE_USER: begin
        state_next.pad.oe = cfg_oe_reg ? state_next.oe_q : output_enable;
        if (cfg_out_reg) begin
          state_next.pad.data = sync_pins.out_clk ? state_next.out_q0 : state_next.out_q1;
        end else begin
          state_next.pad.data = d_out_0;
        end
        state_next.pad.pull_en = cfg_pull_en;
        state_next.pad.pull_sel = cfg_pull_sel;
      end
      pcl_pkg::MODE_UNUSED: begin
        state_next.pad.oe = 1'b0;
        state_next.pad.data = 1'b0;
        state_next.pad.pull_en = 1'b0;
        state_next.pad.pull_sel = pcl_pkg::PULL_100K;
      end
      default: begin
        state_next.pad.oe = 1'b0;
        state_next.pad.data = 1'b0;
        state_next.pad.pull_en = 1'b1;
        state_next.pad.pull_sel = pcl_pkg::PULL_100K;
      end
    endcase
    // with the enable low the pad data is forced to 0 in every mode, user mode included
    if (!state_next.pad.oe) begin
      state_next.pad.data = 1'b0;
    end

    // read data stands for one cycle after the read strobe only
    state_next.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        pcl_pkg::CTRL_OFS: begin
          state_next.rdata[pcl_pkg::CTRL_W-1:0] = state_reg.ctrl;
        end
        pcl_pkg::STATUS_OFS: begin
          state_next.rdata[pcl_pkg::STAT_MODE_LSB +: 2] = state_reg.mode;
          state_next.rdata[pcl_pkg::STAT_FROZEN_BIT] = frozen;
          state_next.rdata[pcl_pkg::STAT_PAD_BIT] = sync_pins.pad;
          state_next.rdata[pcl_pkg::STAT_DIN0_BIT] = state_reg.d_in_0;
          state_next.rdata[pcl_pkg::STAT_DIN1_BIT] = state_reg.d_in_1;
          state_next.rdata[pcl_pkg::STAT_POR_BIT] = sync_pins.por_active;
        end
        default: begin
          state_next.rdata = 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state flops; reset leaves the pad floating with the weak pull-up on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg.ctrl <= pcl_pkg::CTRL_RST;
      state_reg.mode <= pcl_pkg::MODE_PRECFG;
      state_reg.in_q0 <= 1'b0;
      state_reg.in_q1 <= 1'b0;
      state_reg.in_hold <= 1'b0;
      state_reg.out_q0 <= 1'b0;
      state_reg.out_q1 <= 1'b0;
      state_reg.oe_q <= 1'b0;
      state_reg.in_clk_prev <= 1'b0;
      state_reg.out_clk_prev <= 1'b0;
      state_reg.pad.data <= 1'b0;
      state_reg.pad.oe <= 1'b0;
      state_reg.pad.pull_en <= 1'b1;
      state_reg.pad.pull_sel <= pcl_pkg::PULL_100K;
      state_reg.d_in_0 <= 1'b0;
      state_reg.d_in_1 <= 1'b0;
      state_reg.rdata <= 32'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign reg_rdata = state_reg.rdata;
  assign d_in_0 = state_reg.d_in_0;
  assign d_in_1 = state_reg.d_in_1;
  assign pad_out = state_reg.pad.data;
  assign pad_oe = state_reg.pad.oe;
  assign pad_pullup_en = state_reg.pad.pull_en;
  assign pad_pullup_sel = state_reg.pad.pull_sel;

endmodule

// file: pcl_pad_model.sv
// Purpose: pad and far-end driver model for the I/O cell
// Assumes: pad_oe high means the cell drives the pad
// Notes: a pad nobody drives or pulls wanders every cycle
`timescale 1ns/100ps
module pcl_pad_model (
  input wire logic clk,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pull_en,
  input wire logic ext_drv,
  input wire logic ext_val,
  output logic pad
);
  logic flt_reg;
  // floating level starts low, then changes so it never passes for a held value
  initial flt_reg = 1'h0;
  always @(posedge clk) flt_reg <= ~flt_reg;
  // cell drive wins, then the far end, then the weak pull-up
  assign pad = pad_oe ? pad_out : ext_drv ? ext_val : pull_en ? 1'h1 : flt_reg;
endmodule

// file: pcl_cell_assertions.sv
// Purpose: port checks for the programmable I/O cell
// Assumes: a shadow of the control word mirrors hidden state
// Notes: usr means user mode settled for seven quiet cycles
`timescale 1ns/100ps
module pcl_cell_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic por_active,
  input wire logic output_enable,
  input wire logic d_out_0,
  input wire logic clock_enable,
  input wire logic latch_input_value,
  input wire logic d_in_0,
  input wire logic d_in_1,
  input wire logic pad_in,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pad_pullup_en,
  input wire logic [1:0] pad_pullup_sel
);
  logic [8:0] sh_reg;
  logic [2:0] age_reg;
  logic usr;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  // shadow control word and quiet cycles since a write or por
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 9'h010;
      age_reg <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == 4'h0) sh_reg <= reg_wdata[8:0];
      if (reg_wr || por_active) age_reg <= 3'h0;
      else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
    end
  end
  assign usr = age_reg == 3'h7 && sh_reg[8:7] == 2'h3;
  a_float_data: assert property (!pad_oe |-> !pad_out) else $error("floating drive");
  a_por_precfg: assert property (por_active [*6] |-> !pad_oe && pad_pullup_en &&
    pad_pullup_sel == 2'h0 && !d_in_0 && !d_in_1) else $error("not in reset state");
  a_unused_off: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[8:7] == 2'h2
    ##1 (!reg_wr && !por_active) [*5] |-> !pad_pullup_en && !pad_oe && !d_in_0)
    else $error("unused not blocked");
  a_direct_out: assert property (usr && !reg_wr && sh_reg[2:1] == 2'h0 |=>
    pad_oe == $past(output_enable) && pad_out == ($past(output_enable) && $past(d_out_0)))
    else $error("direct output wrong");
  a_pull_user: assert property (usr |-> pad_pullup_en == sh_reg[4] &&
    pad_pullup_sel == sh_reg[6:5]) else $error("pull-up wrong");
  a_direct_in: assert property ((usr && !sh_reg[0] && !latch_input_value && $stable(pad_in))
    [*5] |-> d_in_0 == pad_in && d_in_1 == pad_in) else $error("direct input wrong");
  a_freeze_hold: assert property ((usr && sh_reg[3] && !sh_reg[0] && latch_input_value)
    [*3] |-> $stable(d_in_0) && d_in_1 == d_in_0) else $error("frozen input moved");
  a_ce_hold: assert property ((usr && sh_reg[2] && !clock_enable) [*3] |-> $stable(pad_oe))
    else $error("disabled register loaded");
  c_frozen: cover property (usr && sh_reg[3] && latch_input_value);
  c_unused: cover property (age_reg == 3'h7 && sh_reg[8:7] == 2'h2);
  c_reg_out: cover property (usr && sh_reg[1] && pad_oe);
endmodule
bind pcl_cell pcl_cell_assertions chk_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .por_active,
  .output_enable, .d_out_0, .clock_enable, .latch_input_value, .d_in_0, .d_in_1, .pad_in,
  .pad_out, .pad_oe, .pad_pullup_en, .pad_pullup_sel);

// file: test_programmable_io_cell.sv
// Purpose: self-checking bench for the programmable I/O cell
// Assumes: 40 MHz clk, pad side given by pcl_pad_model
// Notes: reads and pad samples share one queue of notes
`timescale 1ns/100ps
module test_programmable_io_cell;
  logic clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, smp = 1'h0, rd_seen = 1'h0;
  logic input_clk = 1'h0, output_clk = 1'h0, clock_enable = 1'h1, output_enable = 1'h0;
  logic d_out_0 = 1'h0, d_out_1 = 1'h0, latch_input_value = 1'h0, por_active = 1'h1;
  logic ext_drv = 1'h0, ext_val = 1'h0, d_in_0, d_in_1, pad_in, pad_out, pad_oe, pad_pullup_en;
  logic [1:0] pad_pullup_sel;
  logic [3:0] reg_addr = 4'h0;
  logic [6:0] m;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, w, r;
  logic [31:0] exp_q[$];
  int err_total = 0, n_tests = 0, seed = 46, cyc = 0;
  wire logic [6:0] obs = {pad_out, pad_oe, pad_pullup_en, pad_pullup_sel, d_in_0, d_in_1};
  pcl_cell dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .input_clk,
    .output_clk, .clock_enable, .output_enable, .d_out_0, .d_out_1, .latch_input_value, .d_in_0,
    .d_in_1, .pad_in, .por_active, .pad_out, .pad_oe, .pad_pullup_en, .pad_pullup_sel);
  pcl_pad_model pad_u (.clk, .pad_out, .pad_oe, .pull_en(pad_pullup_en), .ext_drv, .ext_val,
    .pad(pad_in));
  initial forever #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    tick(1);
    reg_wr <= 1'h0;
    tick(1);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    reg_addr <= a;
    reg_rd <= 1'h1;
    tick(1);
    reg_rd <= 1'h0;
    tick(1);
  endtask
  // note masked pad outputs, sampled at the next edge
  task automatic expect_pad(input logic [6:0] mk, input logic [6:0] v);
    exp_q.push_back({18'h0, mk, v});
    smp <= 1'h1;
    tick(1);
    smp <= 1'h0;
    tick(1);
  endtask
  task automatic phase(input logic l, input logic [6:0] mk, input logic [6:0] v);
    input_clk <= l;
    output_clk <= l;
    tick(8);
    expect_pad(mk, v);
  endtask
  // watch outputs, take the oldest note, cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
    if (smp) begin
      w = exp_q.pop_front();
      check({25'h0, obs & w[13:7]}, {25'h0, w[6:0] & w[13:7]});
    end
    rd_seen = reg_rd;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    tick(10);
    rst <= 1'h0;
    tick(2);
    expect_pad(7'h7f, 7'h10);
    wr_reg(4'h4, 32'h1ff);
    rd_reg(4'h0, 32'h10);
    rd_reg(4'h8, 32'h0);
    wr_reg(4'h0, 32'h1b0);
    output_enable <= 1'h1;
    d_out_0 <= 1'h1;
    tick(8);
    expect_pad(7'h7f, 7'h10);
    por_active <= 1'h0;
    tick(8);
    expect_pad(7'h7f, 7'h77);
    rd_reg(4'h4, 32'h39);
    // random direct drive over every pull-up strength
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      wr_reg(4'h0, {23'h0, 2'h3, i[1:0], r[2], 4'h0});
      output_enable <= r[3];
      d_out_0 <= r[4];
      ext_drv <= r[5];
      ext_val <= r[6];
      m = {5'h1f, {2{r[3] | r[5] | r[2]}}};
      tick(10);
      expect_pad(m, {r[3] & r[4], r[3], r[2], i[1:0], {2{r[3] ? r[4] : !r[5] | r[6]}}});
    end
    // freeze with and without the latch enabled
    output_enable <= 1'h0;
    ext_drv <= 1'h1;
    for (int k = 0; k < 2; k++) begin
      wr_reg(4'h0, {23'h0, 5'h19, k[0], 3'h0});
      ext_val <= 1'h1;
      tick(10);
      latch_input_value <= 1'h1;
      tick(2);
      ext_val <= 1'h0;
      tick(8);
      expect_pad(7'h03, {5'h0, k[0], k[0]});
      latch_input_value <= 1'h0;
      tick(8);
      expect_pad(7'h03, 7'h0);
    end
    wr_reg(4'h0, 32'h110);
    output_enable <= 1'h1;
    ext_val <= 1'h1;
    tick(8);
    expect_pad(7'h73, 7'h0);
    // registered paths on both clock edges
    r = $random(seed);
    ext_drv <= 1'h0;
    d_out_0 <= r[0];
    d_out_1 <= r[1];
    wr_reg(4'h0, 32'h187);
    rd_reg(4'h0, 32'h187);
    phase(1'h1, 7'h60, {r[0], 6'h20});
    phase(1'h0, 7'h60, {r[1], 6'h20});
    clock_enable <= 1'h0;
    d_out_0 <= ~r[0];
    phase(1'h1, 7'h60, {r[0], 6'h20});
    clock_enable <= 1'h1;
    output_enable <= 1'h0;
    phase(1'h0, 7'h60, {r[1], 6'h20});
    phase(1'h1, 7'h60, 7'h0);
    ext_drv <= 1'h1;
    ext_val <= r[2];
    tick(3);
    phase(1'h0, 7'h01, {6'h0, r[2]});
    ext_val <= r[3];
    tick(3);
    phase(1'h1, 7'h03, {5'h0, r[3], r[2]});
    por_active <= 1'h1;
    tick(8);
    expect_pad(7'h7f, 7'h10);
    give_verdict();
  end
endmodule
